/* design/dhr_regs.v */
// host register bank for the decoder: interrupt b, input routing, lock and
// standard control, program ram write port, restart strobe and lock status.
// assumes: host port logic presents single-cycle read/write strobes with a
// 9-bit address (vip addresses carry the 100h offset), and decoder status
// inputs come from outside this clock domain.
//
// What this block does
// - mask bit one passes source, default zero
// - mask layout: bits 0-5 sources, bit 7 init
// - mask gates pin and active bit, status still sets
// - pin and active bit equal status AND mask
// - config bit 0 polarity, one high, default
// - low mode open drain, high mode push-pull
// - route bits pick first or second converter
// - lock speed bit one enables fast lock
// - crystal bit zero 14.31818, one 27 MHz
// - standard field zero auto, 1..10 forced
// - 7E writes program ram, vip uses fifo
// - any write to 7F restarts the cpu
// - 80h reads major revision, read only
// - status bits 3..1 show lock states
// - status bits 7,6,5,0 show signal format
// - status bit 4 latches loss, read clears
// - reset register ones clear status bits
// - status bits stick until host clears
`timescale 1ns/1ps
`default_nettype none
`include "dhr_consts.vh"
module dhr_regs
#(
   parameter [7:0] MAJOR_REVISION = 8'h01 // arbitrary value
)
(
   input wire clk_sys,
   input wire rst,
   input wire vip_mode,
   input wire host_wr,
   input wire host_rd,
   input wire [8:0] host_addr,
   input wire [7:0] host_wdata,
   output reg [7:0] host_rdata_r,
   output reg host_rvalid_r,
   output reg host_ack_r,
   input wire vip_fifo_wr,
   input wire [2:0] vip_fifo_loc,
   input wire [7:0] vip_fifo_data,
   input wire [7:0] irq_src_event,
   input wire [7:0] decoder_status,
   input wire lock_lost_event,
   output reg irq_b_pin_o_r,
   output reg irq_b_pin_oe_n_r,
   output reg [1:0] chan_route_r,
   output reg fast_lock_r,
   output reg xtal_27mhz_r,
   output reg [3:0] std_force_r,
   output reg std_auto_r,
   output reg pram_we_r,
   output reg [7:0] pram_wdata_r,
   output reg cpu_restart_r
);
   // ==========================================================
   // address decode
   // match a register at its subaddress or its vip alias
   function hit;
      input [8:0] a;
      input [8:0] reg_a;
      input vip_ok;
      begin
         hit = (a == reg_a) || (vip_ok && (a == reg_a + `DHR_VIP_BASE));
      end
   endfunction

   reg [7:0] mask_r;
   reg [7:0] cfg_r;
   reg [7:0] irq_status_r;
   reg lost_lock_r;
   reg [7:0] sts_s1_r, sts_s2_r, sts_s3_r;
   reg [7:0] ev_s1_r, ev_s2_r, ev_s3_r;
   reg ll_s1_r, ll_s2_r, ll_s3_r;
   reg [7:0] sts_ok_r;
   reg [7:0] ev_ok_r;
   reg ll_ok_r;
   wire [7:0] irq_set;
   wire [7:0] irq_clr;
   wire lost_set;
   wire irq_any;
   wire [7:0] lock_status_val;

   // ==========================================================
   // input synchronisers: three flops; stage one feeds stage two only
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         sts_s1_r <= `DHR_ZERO8;
         sts_s2_r <= `DHR_ZERO8;
         sts_s3_r <= `DHR_ZERO8;
         ev_s1_r <= `DHR_ZERO8;
         ev_s2_r <= `DHR_ZERO8;
         ev_s3_r <= `DHR_ZERO8;
         ll_s1_r <= 1'b0;
         ll_s2_r <= 1'b0;
         ll_s3_r <= 1'b0;
      end
      else
      begin
         sts_s1_r <= decoder_status;
         sts_s2_r <= sts_s1_r;
         sts_s3_r <= sts_s2_r;
         ev_s1_r <= irq_src_event;
         ev_s2_r <= ev_s1_r;
         ev_s3_r <= ev_s2_r;
         ll_s1_r <= lock_lost_event;
         ll_s2_r <= ll_s1_r;
         ll_s3_r <= ll_s2_r;
      end
   end

   // a source counts as risen once stages two and three agree on a high
   // that the agreed level has not yet seen; bit 6 has no source
   assign irq_set = ev_s2_r & ev_s3_r & ~ev_ok_r & `DHR_SRC_VALID;
   assign lost_set = ll_s2_r & ll_s3_r & ~ll_ok_r;
   assign irq_clr = (host_wr && hit(host_addr, `DHR_A_IRQ_RESET, 1'b1)) ?
                    host_wdata : `DHR_ZERO8;
   assign irq_any = |(irq_status_r & mask_r);
   assign lock_status_val = {sts_ok_r[7:5], lost_lock_r, sts_ok_r[3:0]};

   // ==========================================================
   // per source: agreed levels and sticky status bit; set wins over clear
   // so an event landing in the cycle of a host clear is never lost
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_src
         always @(posedge clk_sys)
         begin
            if (rst)
            begin
               sts_ok_r[gi] <= 1'b0;
               ev_ok_r[gi] <= 1'b0;
               irq_status_r[gi] <= 1'b0;
            end
            else
            begin
               // a level is taken only while stages two and three agree
               if (sts_s2_r[gi] == sts_s3_r[gi])
                  sts_ok_r[gi] <= sts_s3_r[gi];
               if (ev_s2_r[gi] == ev_s3_r[gi])
                  ev_ok_r[gi] <= ev_s3_r[gi];
               // masked sources still set their status bit
               if (irq_set[gi])
                  irq_status_r[gi] <= 1'b1;
               else if (irq_clr[gi])
                  irq_status_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================
   // lost-lock latch: any loss sets it, a read of the status clears it
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         lost_lock_r <= 1'b0;
         ll_ok_r <= 1'b0;
      end
      else
      begin
         if (ll_s2_r == ll_s3_r)
            ll_ok_r <= ll_s3_r;
         if (lost_set)
         begin
            lost_lock_r <= 1'b1;
         end
         else if (host_rd && hit(host_addr, `DHR_A_LOCK_STATUS, 1'b1))
         begin
            lost_lock_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // control registers and write strobes
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         mask_r <= `DHR_ZERO8;
         cfg_r <= `DHR_CFG_RESET;
         chan_route_r <= 2'b00;
         fast_lock_r <= 1'b0;
         xtal_27mhz_r <= 1'b0;
         std_force_r <= `DHR_STD_AUTO;
         std_auto_r <= 1'b1;
         pram_we_r <= 1'b0;
         pram_wdata_r <= `DHR_ZERO8;
         cpu_restart_r <= 1'b0;
      end
      else
      begin
         pram_we_r <= 1'b0;
         cpu_restart_r <= 1'b0;
         if (host_wr)
         begin
            if (hit(host_addr, `DHR_A_IRQ_MASK, 1'b1))
               mask_r <= host_wdata & `DHR_SRC_VALID;
            if (hit(host_addr, `DHR_A_IRQ_CFG, 1'b1))
               cfg_r <= host_wdata & `DHR_ONE_BIT;
            if (hit(host_addr, `DHR_A_CHAN_ROUTE, 1'b1))
               chan_route_r <= host_wdata[1:0];
            if (hit(host_addr, `DHR_A_LOCK_SPEED, 1'b1))
               fast_lock_r <= host_wdata[0];
            if (hit(host_addr, `DHR_A_XTAL_SEL, 1'b1))
               xtal_27mhz_r <= host_wdata[0];
            // codes above the last forced standard are ignored
            if (hit(host_addr, `DHR_A_STD_FORCE, 1'b1) && host_wdata[3:0] <= `DHR_STD_LAST)
            begin
               std_force_r <= host_wdata[3:0];
               std_auto_r <= (host_wdata[3:0] == `DHR_STD_AUTO);
            end
            if (hit(host_addr, `DHR_A_CPU_RESTART, 1'b1))
               cpu_restart_r <= 1'b1;
         end
         // program ram: subaddress port outside vip mode, fifo b in vip mode
         if (!vip_mode && host_wr && host_addr == `DHR_A_PRAM_WRITE)
         begin
            pram_we_r <= 1'b1;
            pram_wdata_r <= host_wdata;
         end
         else if (vip_mode && vip_fifo_wr && vip_fifo_loc == `DHR_VIP_PRAM_LOC)
         begin
            pram_we_r <= 1'b1;
            pram_wdata_r <= vip_fifo_data;
         end
      end
   end

   // ==========================================================
   // interrupt pin: open drain when active low, push-pull when active high
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         irq_b_pin_o_r <= 1'b0;
         irq_b_pin_oe_n_r <= 1'b0; // default active-high, driven low
      end
      else if (cfg_r[`DHR_CFG_POL])
      begin
         irq_b_pin_o_r <= irq_any;
         irq_b_pin_oe_n_r <= 1'b0;
      end
      else
      begin
         irq_b_pin_o_r <= 1'b0;
         irq_b_pin_oe_n_r <= ~irq_any; // released when idle
      end
   end

   // ==========================================================
   // read path: data one cycle after the read strobe; ack for every access
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         host_rdata_r <= `DHR_ZERO8;
         host_rvalid_r <= 1'b0;
         host_ack_r <= 1'b0;
      end
      else
      begin
         host_rvalid_r <= host_rd;
         host_ack_r <= host_rd | host_wr;
         host_rdata_r <= `DHR_ZERO8; // unmapped and write-only read zero
         if (host_rd)
         begin
            if (hit(host_addr, `DHR_A_IRQ_MASK, 1'b1))
               host_rdata_r <= mask_r;
            else if (hit(host_addr, `DHR_A_IRQ_CFG, 1'b1))
               host_rdata_r <= cfg_r;
            else if (hit(host_addr, `DHR_A_CHAN_ROUTE, 1'b1))
               host_rdata_r <= {6'h00, chan_route_r};
            else if (hit(host_addr, `DHR_A_LOCK_SPEED, 1'b1))
               host_rdata_r <= {7'h00, fast_lock_r};
            else if (hit(host_addr, `DHR_A_XTAL_SEL, 1'b1))
               host_rdata_r <= {7'h00, xtal_27mhz_r};
            else if (hit(host_addr, `DHR_A_STD_FORCE, 1'b1))
               host_rdata_r <= {4'h0, std_force_r};
            else if (hit(host_addr, `DHR_A_MAJOR_REV, 1'b1))
               host_rdata_r <= MAJOR_REVISION;
            else if (hit(host_addr, `DHR_A_LOCK_STATUS, 1'b1))
               host_rdata_r <= lock_status_val;
            else if (hit(host_addr, `DHR_A_IRQ_STATUS, 1'b1))
               host_rdata_r <= irq_status_r;
            else if (hit(host_addr, `DHR_A_IRQ_ACTIVE, 1'b1))
               host_rdata_r <= {7'h00, irq_any};
         end
      end
   end
endmodule // dhr_regs
`default_nettype wire

/* design/dhr_consts.vh */
// constants for the decoder host register bank (interrupt b channel)
// assumes: included by dhr_regs.v only; definitions only
`ifndef DHR_CONSTS_VH
`define DHR_CONSTS_VH
// ==========================================================
// subaddresses (parallel and serial host ports)
`define DHR_A_IRQ_RESET 9'h01C
`define DHR_A_IRQ_MASK 9'h01D
`define DHR_A_IRQ_CFG 9'h01E
`define DHR_A_CHAN_ROUTE 9'h020
`define DHR_A_LOCK_SPEED 9'h025
`define DHR_A_XTAL_SEL 9'h026
`define DHR_A_STD_FORCE 9'h028
`define DHR_A_PRAM_WRITE 9'h07E
`define DHR_A_CPU_RESTART 9'h07F
`define DHR_A_MAJOR_REV 9'h080
`define DHR_A_LOCK_STATUS 9'h081
`define DHR_A_IRQ_STATUS 9'h085
`define DHR_A_IRQ_ACTIVE 9'h086
// offset of the vip register window
`define DHR_VIP_BASE 9'h100
// ==========================================================
// field layouts and reset values
`define DHR_SRC_VALID 8'hBF
`define DHR_CFG_POL 0
`define DHR_CFG_RESET 8'h01
`define DHR_ROUTE_MASK 8'h03
`define DHR_ONE_BIT 8'h01
`define DHR_STD_MASK 8'h0F
`define DHR_STD_AUTO 4'h0
`define DHR_STD_LAST 4'hA
`define DHR_ST_LOST 4
`define DHR_ZERO8 8'h00
// vip fifo b location that carries program ram writes
`define DHR_VIP_PRAM_LOC 3'h5
`endif

/* verification/dhr_host.sv */
// host processor model: single byte reads and writes on the strobes
// assumes: the bank takes a strobe on a rising clk_sys edge
`timescale 1ns/1ps
`default_nettype none
// ====================
// host port driver
module dhr_host
(
   input wire logic clk_sys,
   output logic host_wr,
   output logic host_rd,
   output logic [8:0] host_addr,
   output logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata_r,
   input wire logic host_ack_r
);
   initial
   begin
      {host_wr, host_rd, host_addr, host_wdata} = '0;
   end
   // one strobe cycle; answer taken with the ack, lines scrambled after
   task automatic xfer(input logic w, input logic [8:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(negedge clk_sys);
      {host_wr, host_rd, host_addr, host_wdata} = {w, !w, a, d};
      @(negedge clk_sys);
      {host_wr, host_rd, host_addr, host_wdata} = {2'h0, ~a, ~d};
      q = host_ack_r ? host_rdata_r : 8'hXX;
   endtask
endmodule // dhr_host
`default_nettype wire

/* verification/dhr_regs_sva.sv */
// port checker for dhr_regs
// assumes: bound to every dhr_regs instance
`timescale 1ns/1ps
`default_nettype none
// ====================
// checker
module dhr_regs_sva
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic vip_mode,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [8:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic host_rvalid_r,
   input wire logic vip_fifo_wr,
   input wire logic [2:0] vip_fifo_loc,
   input wire logic [1:0] chan_route_r,
   input wire logic fast_lock_r,
   input wire logic xtal_27mhz_r,
   input wire logic [3:0] std_force_r,
   input wire logic std_auto_r,
   input wire logic pram_we_r,
   input wire logic [7:0] pram_wdata_r,
   input wire logic cpu_restart_r,
   input wire logic irq_b_pin_o_r,
   input wire logic irq_b_pin_oe_n_r
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // low address byte; the vip alias folds onto it
   logic [7:0] lo;
   assign lo = host_addr[7:0];
   a_read_answer: assert property (host_rd |=> host_rvalid_r)
      else $error("read not answered");
   a_restart_set: assert property (host_wr && lo == 8'h7F |=> cpu_restart_r)
      else $error("restart missing");
   a_restart_only: assert property (cpu_restart_r |-> $past(host_wr && lo == 8'h7F))
      else $error("restart without write");
   a_pram_write: assert property (host_wr && host_addr == 9'h07E && !vip_mode
      |=> pram_we_r && pram_wdata_r == $past(host_wdata)) else $error("pram write lost");
   a_pram_only: assert property (pram_we_r |-> $past(host_wr && host_addr == 9'h07E &&
      !vip_mode || vip_fifo_wr && vip_mode && vip_fifo_loc == 3'h5))
      else $error("pram write without cause");
   a_auto_flag: assert property (std_auto_r == (std_force_r == 4'h0))
      else $error("auto flag wrong");
   a_std_range: assert property (std_force_r <= 4'hA)
      else $error("standard code out of range");
   a_route_write: assert property (host_wr && lo == 8'h20
      |=> chan_route_r == $past(host_wdata[1:0])) else $error("route not written");
   a_fast_write: assert property (host_wr && lo == 8'h25
      |=> fast_lock_r == $past(host_wdata[0])) else $error("lock speed not written");
   a_xtal_write: assert property (host_wr && lo == 8'h26
      |=> xtal_27mhz_r == $past(host_wdata[0])) else $error("crystal not written");
   a_std_write: assert property (host_wr && lo == 8'h28 && host_wdata[3:0] <= 4'hA
      |=> std_force_r == $past(host_wdata[3:0])) else $error("standard not written");
   a_std_refuse: assert property (host_wr && lo == 8'h28 && host_wdata[3:0] > 4'hA
      |=> $stable(std_force_r)) else $error("bad standard code taken");
   a_pin_push: assert property (irq_b_pin_o_r |-> !irq_b_pin_oe_n_r)
      else $error("pin high while released");
   a_pin_low_mode: assert property (host_wr && lo == 8'h1E && !host_wdata[0]
      |=> ##1 !irq_b_pin_o_r) else $error("pin driven high in low mode");
endmodule // dhr_regs_sva
bind dhr_regs dhr_regs_sva chk (.*);
`default_nettype wire

/* verification/test_dhr_regs.sv */
// self-checking bench for dhr_regs with a mirror of the bank
// assumes: dhr_host and dhr_regs_sva compiled first
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench
module test_dhr_regs;
   logic clk_sys, rst, vip_mode, host_wr, host_rd, host_rvalid_r, host_ack_r;
   logic vip_fifo_wr, lock_lost_event, irq_b_pin_o_r, irq_b_pin_oe_n_r;
   logic fast_lock_r, xtal_27mhz_r, std_auto_r, pram_we_r, cpu_restart_r;
   logic [8:0] host_addr;
   logic [7:0] host_wdata, host_rdata_r, vip_fifo_data, irq_src_event;
   logic [7:0] decoder_status, pram_wdata_r, q, lf, sts, msk;
   logic [2:0] vip_fifo_loc;
   logic [1:0] chan_route_r;
   logic [3:0] std_force_r, sm;
   int n_errors = 0, total_checks = 0, i;
   dhr_regs DUT (.*);
   dhr_host host (.*);
   // clock, 100 ns period
   initial
   begin
      clk_sys = 0;
      forever #50 clk_sys = ~clk_sys;
   end
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      host.xfer(1'h1, a, d, q);
   endtask
   task automatic rd(input logic [8:0] a, input logic [7:0] e);
      host.xfer(1'h0, a, 8'h00, q);
      chk(q, e);
      chk({7'h00, host_rvalid_r}, 8'h01);
   endtask
   // pin against mirror: p is the polarity bit
   task automatic pin(input logic p);
      logic act;
      act = |(sts & msk);
      repeat (2) @(negedge clk_sys);
      chk({6'h00, irq_b_pin_o_r, irq_b_pin_oe_n_r}, p ? {6'h00, act, 1'h0} : {7'h00, !act});
      rd(9'h086, {7'h00, act});
   endtask
   task automatic wrap_up;
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // watchdog, far beyond the expected run
   initial
   begin
      #500000;
      n_errors++;
      wrap_up;
   end
   // main sequence
   initial
   begin
      {rst, vip_mode, vip_fifo_wr, lock_lost_event, vip_fifo_loc} = 7'h40;
      {irq_src_event, decoder_status, vip_fifo_data, sts, sm} = '0;
      lf = 8'h21;
      repeat (2) @(negedge clk_sys);
      rst = 0;
      rd(9'h01D, 8'h00);
      rd(9'h01E, 8'h01);
      wr(9'h180, 8'h5A);
      rd(9'h080, 8'h01);
      chk({chan_route_r, fast_lock_r, xtal_27mhz_r, std_force_r}, 8'h00);
      chk({6'h00, irq_b_pin_o_r, irq_b_pin_oe_n_r}, 8'h00);
      chk({7'h00, std_auto_r}, 8'h01);
      $display("test reset done");
      for (i = 0; i < 16; i++)
      begin
         lf = nxt(lf);
         wr({i[0], 8'h20}, lf);
         wr({i[1], 8'h25}, lf);
         wr({i[2], 8'h26}, lf >> 1);
         wr({i[3], 8'h28}, i[7:0]);
         if (i <= 10)
            sm = i[3:0];
         chk({chan_route_r, fast_lock_r, xtal_27mhz_r, std_force_r}, {lf[1:0], lf[0], lf[1], sm});
         chk({7'h00, std_auto_r}, {7'h00, sm == 4'h0});
      end
      $display("test controls done");
      msk = 8'h05;
      wr(9'h01D, msk);
      rd(9'h11D, msk);
      for (i = 0; i < 8; i++)
      begin
         irq_src_event = 8'h01 << i;
         sts = sts | (irq_src_event & 8'hBF);
         repeat (6) @(negedge clk_sys);
         irq_src_event = 8'h00;
         rd(9'h085, sts);
         pin(1'h1);
      end
      wr(9'h11E, 8'h00);
      pin(1'h0);
      wr(9'h01C, 8'h00);
      rd(9'h085, sts);
      wr(9'h01C, 8'h01);
      sts = sts & 8'hFE;
      pin(1'h0);
      wr(9'h01C, 8'h04);
      sts = sts & 8'hFB;
      pin(1'h0);
      rd(9'h085, sts);
      // source edge reaches status in the very cycle of a clear of that bit
      irq_src_event = 8'h01;
      repeat (2) @(negedge clk_sys);
      wr(9'h01C, 8'h01);
      irq_src_event = 8'h00;
      sts = sts | 8'h01;
      rd(9'h085, sts);
      pin(1'h0);
      $display("test interrupt done");
      lf = nxt(lf);
      decoder_status = lf;
      lock_lost_event = 1;
      repeat (6) @(negedge clk_sys);
      lock_lost_event = 0;
      rd(9'h081, lf | 8'h10);
      rd(9'h181, lf & 8'hEF);
      $display("test status done");
      wr(9'h07E, 8'hA5);
      chk(pram_wdata_r & {8{pram_we_r}}, 8'hA5);
      {vip_fifo_wr, vip_fifo_loc, vip_fifo_data} = {4'hD, lf};
      @(negedge clk_sys);
      vip_fifo_wr = 0;
      chk({7'h00, pram_we_r}, 8'h00);
      vip_mode = 1;
      wr(9'h07E, 8'h11);
      chk({7'h00, pram_we_r}, 8'h00);
      {vip_fifo_wr, vip_fifo_loc, vip_fifo_data} = {4'hD, lf};
      @(negedge clk_sys);
      vip_fifo_wr = 0;
      chk(pram_wdata_r & {8{pram_we_r}}, lf);
      wr(9'h17F, 8'h3C);
      chk({7'h00, cpu_restart_r}, 8'h01);
      $display("test program ram done");
      wrap_up;
   end
endmodule // test_dhr_regs
`default_nettype wire
